// ===== core/spef_pkg.sv
// Package of constants for the serial port enable and ready flag block.
// Assumes a 32-bit APB register bus and buffer logic that reports counts.
package spef_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] ctrl_status_addr = 12'h004;
	localparam logic [11:0] irq_status_addr  = 12'h008;
	localparam logic [11:0] irq_mask_addr    = 12'h00c;

	// ==========================================================
	// Field positions
	localparam int rx_enable_bit       = 0;
	localparam int tx_enable_bit       = 1;
	localparam int tx_ready_bit        = 8;
	localparam int rx_ready_bit        = 10;

	// Interrupt status bits.
	localparam int irq_tx_ready_bit    = 0;
	localparam int irq_rx_ready_bit    = 1;
	localparam int irq_width           = 2;

	// ==========================================================
	// Reset values
	localparam logic       enable_reset   = 1'b0;
	localparam logic [1:0] irq_mask_reset = 2'h0;

	// ==========================================================
	// Path state
	typedef enum logic [1:0]
	{
		spef_off     = 2'b00,
		spef_flush   = 2'b01,
		spef_run     = 2'b11
	} spef_path_t;

endpackage

// ===== core/spef_path_if.sv
// Interface between the register front end and one path controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface spef_path_if;
	logic enable;
	logic running;
	logic flush;

	modport ctrl
	(
		input  enable,
		output running,
		output flush
	);

	modport regs
	(
		output enable,
		input  running,
		input  flush
	);
endinterface

// ===== core/spef_path.sv
// One path controller: turns the enable level into a run level and a flush pulse.
// Assumes the enable comes from a register on the same clock.
`timescale 1ns/1ps
module spef_path
(
	// Clock and reset
	input  wire logic    pclk,
	input  wire logic    presetn,
	// Control
	spef_path_if.ctrl    path
);

	// ==========================================================
	// State machine
	spef_pkg::spef_path_t state;
	spef_pkg::spef_path_t next_state;

	always_comb
	begin
		next_state = state;
		unique case (state)
			spef_pkg::spef_off:
			begin
				if (path.enable)
					next_state = spef_pkg::spef_run;
			end
			spef_pkg::spef_run:
			begin
				if (!path.enable)
					next_state = spef_pkg::spef_flush;
			end
			spef_pkg::spef_flush:
			begin
				next_state = path.enable ? spef_pkg::spef_run : spef_pkg::spef_off;
			end
			default:
			begin
				next_state = spef_pkg::spef_off;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= spef_pkg::spef_off;
		else
			state <= next_state;
	end

	// Running follows the enable at once so no cycle is lost on start or stop.
	assign path.running = path.enable;
	// One-cycle flush pulse after a disable.
	assign path.flush   = (state == spef_pkg::spef_flush);

endmodule

// ===== core/spef_top.sv
// Serial port control and status word with enable bits, ready flags and interrupts.
// Assumes buffer logic on pclk that supplies occupancy counts and obeys flush.
//
// Overview of operation
// - Setting the receive enable starts reception in the cycle after the write.
// - Clearing the receive enable flushes the receive buffer with a one-cycle pulse.
// - Setting the transmit enable starts transmission in the cycle after the write.
// - Clearing the transmit enable halts sending at once and discards pending data.
// - The transmit ready flag is high exactly while tx space is nonzero and tx is enabled.
// - The receive ready flag is high exactly while rx fill is nonzero and rx is enabled.
// - Writing 0 or 1 to an enable bit disables or enables the path; reads return it.
`timescale 1ns/1ps
module spef_top
#(
	parameter int count_width = 8
)
(
	// APB
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Buffer logic
	input  wire logic [count_width-1:0] tx_buffer_space_count,
	input  wire logic [count_width-1:0] rx_buffer_fill_count,
	output logic                        rx_run,
	output logic                        tx_run,
	output logic                        rx_flush,
	output logic                        tx_flush,
	// Interrupt
	output logic                        irq
);

	// ==========================================================
	// Bus decode
	function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
		hit = (a == target);
	endfunction

	logic access;
	logic wr;
	logic mapped;

	assign access  = psel && penable;
	assign wr      = access && pwrite;
	assign mapped  = hit(paddr, spef_pkg::ctrl_status_addr)
		|| hit(paddr, spef_pkg::irq_status_addr)
		|| hit(paddr, spef_pkg::irq_mask_addr);
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// ==========================================================
	// Enable registers
	logic rx_enable;
	logic tx_enable;
	logic next_rx_enable;
	logic next_tx_enable;

	always_comb
	begin
		next_rx_enable = rx_enable;
		next_tx_enable = tx_enable;
		if (wr && hit(paddr, spef_pkg::ctrl_status_addr))
		begin
			next_rx_enable = pwdata[spef_pkg::rx_enable_bit];
			next_tx_enable = pwdata[spef_pkg::tx_enable_bit];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_enable <= spef_pkg::enable_reset;
			tx_enable <= spef_pkg::enable_reset;
		end
		else
		begin
			rx_enable <= next_rx_enable;
			tx_enable <= next_tx_enable;
		end
	end

	// ==========================================================
	// Path controllers
	spef_path_if rx_if ();
	spef_path_if tx_if ();

	assign rx_if.enable = rx_enable;
	assign tx_if.enable = tx_enable;

	spef_path u_rx
	(
		.pclk    (pclk),
		.presetn (presetn),
		.path    (rx_if)
	);

	spef_path u_tx
	(
		.pclk    (pclk),
		.presetn (presetn),
		.path    (tx_if)
	);

	assign rx_run   = rx_if.running;
	assign tx_run   = tx_if.running;
	assign rx_flush = rx_if.flush;
	// Pending transmit data is dropped on the same pulse that follows the halt.
	assign tx_flush = tx_if.flush;

	// ==========================================================
	// Ready flags
	logic tx_ready;
	logic rx_ready;

	assign tx_ready = tx_enable && (tx_buffer_space_count != '0);
	assign rx_ready = rx_enable && (rx_buffer_fill_count != '0);

	// ==========================================================
	// Interrupts: sticky on rising ready, set wins over clear.
	logic [spef_pkg::irq_width-1:0] irq_status;
	logic [spef_pkg::irq_width-1:0] irq_mask;
	logic [spef_pkg::irq_width-1:0] ready_prev;
	logic [spef_pkg::irq_width-1:0] ready_now;
	logic [spef_pkg::irq_width-1:0] next_irq_status;
	logic [spef_pkg::irq_width-1:0] next_irq_mask;

	assign ready_now[spef_pkg::irq_tx_ready_bit] = tx_ready;
	assign ready_now[spef_pkg::irq_rx_ready_bit] = rx_ready;

	always_comb
	begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (wr && hit(paddr, spef_pkg::irq_status_addr))
			next_irq_status = irq_status & ~pwdata[spef_pkg::irq_width-1:0];
		if (wr && hit(paddr, spef_pkg::irq_mask_addr))
			next_irq_mask = pwdata[spef_pkg::irq_width-1:0];
		next_irq_status = next_irq_status | (ready_now & ~ready_prev);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= '0;
			irq_mask   <= spef_pkg::irq_mask_reset;
			ready_prev <= '0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			ready_prev <= ready_now;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ==========================================================
	// Read data, registered at the setup cycle so it stands in the access phase.
	logic [31:0] next_prdata;

	always_comb
	begin
		next_prdata = '0;
		if (psel && !penable && !pwrite)
		begin
			if (hit(paddr, spef_pkg::ctrl_status_addr))
			begin
				next_prdata[spef_pkg::rx_enable_bit] = rx_enable;
				next_prdata[spef_pkg::tx_enable_bit] = tx_enable;
				next_prdata[spef_pkg::tx_ready_bit]  = tx_ready;
				next_prdata[spef_pkg::rx_ready_bit]  = rx_ready;
			end
			else if (hit(paddr, spef_pkg::irq_status_addr))
				next_prdata[spef_pkg::irq_width-1:0] = irq_status;
			else if (hit(paddr, spef_pkg::irq_mask_addr))
				next_prdata[spef_pkg::irq_width-1:0] = irq_mask;
		end
		else if (access)
			next_prdata = prdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else
			prdata <= next_prdata;
	end

endmodule

// ===== bench/spef_chk.sv
// Assertions on the ports of the serial port control block.
// Assumes one clock and the register map of the design package.
`timescale 1ns/1ps
module spef_chk
#(
	parameter int count_width = 8
)
(
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   rx_run,
	input wire logic                   tx_run,
	input wire logic                   rx_flush,
	input wire logic                   tx_flush,
	input wire logic [count_width-1:0] tx_buffer_space_count,
	input wire logic [count_width-1:0] rx_buffer_fill_count
);
	// ==========================================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ctl = psel && penable && paddr == spef_pkg::ctrl_status_addr;
	wire rd  = ctl && !pwrite;
	wire wr  = ctl && pwrite;
	wire tx_ok = tx_run && tx_buffer_space_count != '0;
	wire rx_ok = rx_run && rx_buffer_fill_count != '0;

	rx_enable_a: assert property (wr |=> rx_run == $past(pwdata[0]))
		else $error("rx run does not follow the write");
	tx_enable_a: assert property (wr |=> tx_run == $past(pwdata[1]))
		else $error("tx run does not follow the write");
	rx_flush_a: assert property ($fell(rx_run) |-> ##[0:1] rx_flush)
		else $error("rx flush missing");
	tx_flush_a: assert property ($fell(tx_run) |-> ##[0:1] tx_flush)
		else $error("tx flush missing");
	tx_ready_a: assert property (rd |-> prdata[8] == $past(tx_ok))
		else $error("tx ready flag wrong");
	rx_ready_a: assert property (rd |-> prdata[10] == $past(rx_ok))
		else $error("rx ready flag wrong");
	enable_readback_a: assert property (rd |-> prdata[1:0] == {tx_run, rx_run})
		else $error("enable readback wrong");
	reserved_zero_a: assert property (rd |-> prdata[31:11] == '0 && prdata[9] == 1'h0 && prdata[7:2] == '0)
		else $error("reserved bits not zero");
	cover property (rd && prdata[10]);
	cover property ($fell(rx_run));
	cover property ($fell(tx_run));
endmodule

// ===== bench/spef_buf_model.sv
// Buffer logic model that supplies occupancy counts and obeys flushes.
// Assumes the bench loads counts with a one-cycle load strobe.
`timescale 1ns/1ps
module spef_buf_model
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       rx_flush,
	input  wire logic       tx_flush,
	input  wire logic       ld,
	input  wire logic [7:0] tx_val,
	input  wire logic [7:0] rx_val,
	// Counts
	output logic      [7:0] tx_space,
	output logic      [7:0] rx_fill
);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tx_space <= 8'h00;
			rx_fill  <= 8'h00;
		end
		else
		begin
			// Discarded pending data frees the whole transmit buffer.
			tx_space <= tx_flush ? 8'hff : (ld ? tx_val : tx_space);
			rx_fill  <= rx_flush ? 8'h00 : (ld ? rx_val : rx_fill);
		end
endmodule

// ===== bench/spef_top_test.sv
// Self-checking bench for the serial port control block.
// Assumes the design package and the buffer model are compiled first.
`timescale 1ns/1ps
module spef_top_test;
	typedef struct packed
	{
		logic [1:0]  en;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [31:0] exp;
	} spef_row_t;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        ld = 1'h0, err, pready, pslverr, rx_run, tx_run, rx_flush, tx_flush, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [7:0]  tx_val = 8'h00, rx_val = 8'h00, tx_cnt, rx_cnt;
	int          n_errors = 0, checks_done = 0;
	spef_row_t   rows [6] = '{'{2'h0, 8'h04, 8'h03, 32'h000}, '{2'h1, 8'h04, 8'h03, 32'h401},
		'{2'h2, 8'h04, 8'h03, 32'h102}, '{2'h3, 8'h00, 8'h03, 32'h403},
		'{2'h3, 8'hff, 8'h00, 32'h103}, '{2'h3, 8'h01, 8'h01, 32'h503}};

	always #2.5 pclk = ~pclk;

	spef_top #(.count_width(8)) spef_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_buffer_space_count(tx_cnt),
		.rx_buffer_fill_count(rx_cnt), .rx_run(rx_run), .tx_run(tx_run),
		.rx_flush(rx_flush), .tx_flush(tx_flush), .irq(irq));
	spef_buf_model spef_buf_model_inst (.pclk(pclk), .presetn(presetn), .rx_flush(rx_flush),
		.tx_flush(tx_flush), .ld(ld), .tx_val(tx_val), .rx_val(rx_val), .tx_space(tx_cnt),
		.rx_fill(rx_cnt));

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog may end this wait; a stuck slave must fail the run.
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic load(input logic [7:0] t, input logic [7:0] x);
		tx_val <= t;
		rx_val <= x;
		ld <= 1'h1;
		@(posedge pclk);
		ld <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic summarize;
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h004, 32'h0);
		chk(r, 32'h0);
		foreach (rows[i])
		begin
			apb(1'h1, 12'h004, {30'h0, rows[i].en});
			load(rows[i].tx, rows[i].rx);
			apb(1'h0, 12'h004, 32'h0);
			chk(r, rows[i].exp);
		end
		load(8'h01, 8'h07);
		apb(1'h1, 12'h004, 32'h1);
		repeat (2) @(posedge pclk);
		chk({24'h0, tx_cnt}, 32'hff);
		apb(1'h1, 12'h004, 32'h2);
		repeat (2) @(posedge pclk);
		chk({24'h0, rx_cnt}, 32'h0);
		apb(1'h0, 12'h004, 32'h0);
		chk(r, 32'h102);
		apb(1'h1, 12'h004, 32'hffff_ffff);
		apb(1'h0, 12'h004, 32'h0);
		chk(r, 32'h103);
		apb(1'h0, 12'h010, 32'h0);
		chk(r | {31'h0, err}, 32'h1);
		apb(1'h1, 12'h00c, 32'h3);
		apb(1'h1, 12'h008, 32'h3);
		chk({31'h0, irq}, 32'h0);
		load(8'hff, 8'h02);
		apb(1'h0, 12'h008, 32'h0);
		chk(r, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'h1, 12'h00c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'h1, 12'h008, 32'h2);
		apb(1'h0, 12'h008, 32'h0);
		chk(r, 32'h0);
		summarize;
	end

	initial
	begin
		repeat (2000) @(posedge pclk);
		n_errors++;
		summarize;
	end
endmodule

bind spef_top spef_chk #(.count_width(count_width)) spef_chk_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .rx_run(rx_run), .tx_run(tx_run), .rx_flush(rx_flush),
	.tx_flush(tx_flush), .tx_buffer_space_count(tx_buffer_space_count),
	.rx_buffer_fill_count(rx_buffer_fill_count));
